// File: include/cpsx_pkg.sv
// Constants, encodings and cycle tables for the single-operand and jump execution unit.
// Assumes an APB master with 32-bit data; every register takes one aligned word.
package cpsx_pkg;

	// --------------------------------------------------------------
	// Register byte addresses.
	// --------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_OPC  = 8'h04;
	localparam logic [7:0] A_OPND = 8'h08;
	localparam logic [7:0] A_PC   = 8'h0c;
	localparam logic [7:0] A_SP   = 8'h10;
	localparam logic [7:0] A_SR   = 8'h14;
	localparam logic [7:0] A_STK0 = 8'h18;
	localparam logic [7:0] A_STK1 = 8'h1c;
	localparam logic [7:0] A_RES  = 8'h20;
	localparam logic [7:0] A_STAT = 8'h24;

	// --------------------------------------------------------------
	// Field positions.
	// --------------------------------------------------------------
	localparam int CB_EXEC = 0;
	localparam int CB_IRQ  = 1;
	localparam int CB_EXIT = 2;
	localparam int FL_C = 0;
	localparam int FL_Z = 1;
	localparam int FL_N = 2;
	localparam int FL_V = 8;
	localparam int ST_BUSY  = 0;
	localparam int ST_DONE  = 1;
	localparam int ST_TAKEN = 2;
	localparam int ST_EXT   = 3;
	localparam int ST_WR    = 4;
	localparam int ST_BAD   = 5;
	localparam int ST_CYC   = 8;
	localparam int ST_WORDS = 12;

	// --------------------------------------------------------------
	// Reset values and steps.
	// --------------------------------------------------------------
	localparam logic [19:0] PC_RST   = 20'h00000;
	localparam logic [19:0] SP_RST   = 20'h00000;
	localparam logic [15:0] SR_RST   = 16'h0000;
	localparam logic [19:0] WORD_STEP = 20'h00002;
	localparam logic [19:0] PAIR_STEP = 20'h00004;

	// --------------------------------------------------------------
	// Instruction encodings.
	// --------------------------------------------------------------
	localparam logic [5:0] F2_PFX = 6'h04;
	localparam logic [2:0] J_PFX  = 3'h1;
	localparam logic [2:0] OP_ROTC = 3'h0;
	localparam logic [2:0] OP_SWAP = 3'h1;
	localparam logic [2:0] OP_SHRA = 3'h2;
	localparam logic [2:0] OP_SEXT = 3'h3;
	localparam logic [2:0] OP_PUSH = 3'h4;
	localparam logic [2:0] OP_CALL = 3'h5;
	localparam logic [2:0] OP_IRET = 3'h6;
	localparam logic [2:0] JC_NZ  = 3'h0;
	localparam logic [2:0] JC_Z   = 3'h1;
	localparam logic [2:0] JC_NC  = 3'h2;
	localparam logic [2:0] JC_C   = 3'h3;
	localparam logic [2:0] JC_N   = 3'h4;
	localparam logic [2:0] JC_GE  = 3'h5;
	localparam logic [2:0] JC_LT  = 3'h6;
	localparam logic [2:0] JC_ALL = 3'h7;

	// --------------------------------------------------------------
	// Cycle counts; tables hold one nibble per addressing mode.
	// --------------------------------------------------------------
	localparam logic [3:0]  CY_JUMP = 4'h2;
	localparam logic [3:0]  CY_IRET = 4'h5;
	localparam logic [3:0]  CY_EXIT = 4'h4;
	localparam logic [3:0]  CY_IRQ  = 4'h6;
	localparam logic [23:0] CY_ROT  = {4'h4, 4'h4, 4'h0, 4'h3, 4'h3, 4'h1};
	localparam logic [23:0] CY_PUSH = {4'h4, 4'h4, 4'h3, 4'h3, 4'h3, 4'h3};
	localparam logic [23:0] CY_CALL = {4'h6, 4'h5, 4'h4, 4'h4, 4'h4, 4'h4};

	typedef enum logic [2:0] {M_REG, M_IND, M_AINC, M_IMM, M_IDX, M_ABS} cpsx_mode_e;
	typedef enum logic [1:0] {K_INSTR, K_IRQ, K_EXIT} cpsx_kind_e;
	typedef enum logic {S_IDLE, S_RUN} cpsx_state_e;

endpackage

// File: logic/cpsx_exec.sv
// Execution unit for single-operand and relative-jump instructions, with APB registers.
// Assumes software supplies the opcode, operand and stack words and reads results back.
// How it works
// - Indexed, symbolic, absolute, immediate fetch an extra word.
// - Rotate right through carry; V cleared.
// - Arithmetic shift keeps MSB, LSB to carry.
// - Push decrements stack pointer by two first.
// - Byte exchange swaps upper and lower bytes.
// - Subroutine entry targets lower 64KB only.
// - Interrupt return pops status then program counter.
// - Sign extend bit 7, flags with C not Z.
// - Jump adds doubled sign-extended offset to counter.
// - Jump reach is -512 to +511 words.
// - Jumps never change status flags.
// - Zero and nonzero branches test Z.
// - Carry and no-carry branches test C.
// - Negative branch only on N set.
// - Signed branches test N xor V.
// - Branch always ignores every flag.
// - Cycles follow format and addressing mode.
// - Interrupt return takes five cycles.
// - Subroutine exit takes four cycles.
// - Interrupt entry takes six cycles.
// - Single-operand cycle table per mode.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module cpsx_exec
	import cpsx_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	// --------------------------------------------------------------
	// Bus handshake.
	// --------------------------------------------------------------
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic        acc;
	logic        wr_acc;
	logic        setup;
	logic        start;

	cpsx_state_e state_q;
	logic [3:0]  cnt_q;
	logic        busy;
	logic        commit;

	logic [15:0] op_q;
	logic [19:0] opnd_q;
	logic [19:0] pc_q;
	logic [19:0] sp_q;
	logic [15:0] sr_q;
	logic [19:0] stk0_q;
	logic [19:0] stk1_q;
	logic [19:0] res_q;
	logic        done_q;
	logic [7:0]  info_q;
	logic [3:0]  cyc_q;

	logic [19:0] p_res_q;
	logic [19:0] p_pc_q;
	logic [19:0] p_sp_q;
	logic [15:0] p_sr_q;

	assign setup  = psel & ~penable;
	assign acc    = psel & penable & pready_q;
	assign wr_acc = acc & pwrite & pstrb[0];
	assign busy   = (state_q == S_RUN);
	assign commit = busy & (cnt_q == 4'h0);
	assign start  = wr_acc & (paddr == A_CTRL) & ~busy & (|pwdata[CB_EXIT:CB_EXEC]);

	// No wait state: the answer is prepared in the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= setup;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			case (paddr)
				A_CTRL: prdata_q <= 32'h0000_0000;
				A_OPC:  prdata_q <= {16'h0000, op_q};
				A_OPND: prdata_q <= {12'h000, opnd_q};
				A_PC:   prdata_q <= {12'h000, pc_q};
				A_SP:   prdata_q <= {12'h000, sp_q};
				A_SR:   prdata_q <= {16'h0000, sr_q};
				A_STK0: prdata_q <= {12'h000, stk0_q};
				A_STK1: prdata_q <= {12'h000, stk1_q};
				A_RES:  prdata_q <= {12'h000, res_q};
				A_STAT: prdata_q <= {18'h00000, info_q[7:6], cyc_q, info_q[5:0], done_q, busy};
				default: pslverr_q <= 1'b1;
			endcase
		end else begin
			pslverr_q <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Decode and execute.
	// --------------------------------------------------------------
	cpsx_kind_e  kind;
	cpsx_mode_e  mode;
	logic        f2;
	logic        branch_always;
	logic        byt;
	logic        ext;
	logic        c;
	logic        z;
	logic        n;
	logic        tkn;
	logic [19:0] d;
	logic [19:0] pcx;
	logic [19:0] off;
	logic [19:0] res_d;
	logic [19:0] pc_d;
	logic [19:0] sp_d;
	logic [15:0] sr_d;
	logic [3:0]  cyc_d;
	logic        wr_d;
	logic        bad_d;

	always_comb begin
		if (pwdata[CB_IRQ]) begin
			kind = K_IRQ;
		end else if (pwdata[CB_EXIT]) begin
			kind = K_EXIT;
		end else begin
			kind = K_INSTR;
		end
	end

	always_comb begin
		f2  = (op_q[15:10] == F2_PFX);
		branch_always = (op_q[15:13] == J_PFX);
		byt = op_q[6];
		case (op_q[5:4])
			2'd0: mode = M_REG;
			2'd1: mode = (op_q[3:0] == 4'h2) ? M_ABS : M_IDX;
			2'd2: mode = M_IND;
			default: mode = (op_q[3:0] == 4'h0) ? M_IMM : M_AINC;
		endcase
		ext = f2 & (mode == M_IDX | mode == M_ABS | mode == M_IMM);
		pcx = pc_q + (ext ? WORD_STEP : 20'h00000);
		d   = opnd_q;
		c   = sr_q[FL_C];
		off = {{9{op_q[9]}}, op_q[9:0], 1'b0};
		tkn   = 1'b0;
		res_d = d;
		pc_d  = pcx;
		sp_d  = sp_q;
		sr_d  = sr_q;
		cyc_d = 4'h1;
		wr_d  = 1'b0;
		bad_d = 1'b0;
		z     = 1'b0;
		n     = 1'b0;
		case (kind)
			K_IRQ: begin
				sp_d  = sp_q - PAIR_STEP;
				res_d = pc_q;
				pc_d  = {4'h0, d[15:0]};
				wr_d  = 1'b1;
				cyc_d = CY_IRQ;
			end
			K_EXIT: begin
				pc_d  = stk0_q;
				sp_d  = sp_q + WORD_STEP;
				cyc_d = CY_EXIT;
			end
			default: begin
				if (branch_always) begin
					cyc_d = CY_JUMP;
					case (op_q[12:10])
						JC_NZ:  tkn = ~sr_q[FL_Z];
						JC_Z:   tkn = sr_q[FL_Z];
						JC_NC:  tkn = ~c;
						JC_C:   tkn = c;
						JC_N:   tkn = sr_q[FL_N];
						JC_GE:  tkn = ~(sr_q[FL_N] ^ sr_q[FL_V]);
						JC_LT:  tkn = sr_q[FL_N] ^ sr_q[FL_V];
						default: tkn = 1'b1;
					endcase
					pc_d = tkn ? pcx + off : pcx;
					sr_d = sr_q;
				end else if (f2) begin
					case (op_q[9:7])
						OP_ROTC, OP_SHRA: begin
							if (op_q[9:7] == OP_ROTC) begin
								n = c;
							end else begin
								n = byt ? d[7] : d[15];
							end
							if (byt) begin
								res_d = {12'h000, n, d[7:1]};
								z     = ({n, d[7:1]} == 8'h00);
							end else begin
								res_d = {4'h0, n, d[15:1]};
								z     = ({n, d[15:1]} == 16'h0000);
							end
							sr_d       = sr_q;
							sr_d[FL_V] = 1'b0;
							sr_d[FL_N] = n;
							sr_d[FL_Z] = z;
							sr_d[FL_C] = d[0];
						end
						OP_SWAP: begin
							res_d = {4'h0, d[7:0], d[15:8]};
						end
						OP_SEXT: begin
							if (mode == M_REG) begin
								res_d = {{12{d[7]}}, d[7:0]};
							end else begin
								res_d = {4'h0, {8{d[7]}}, d[7:0]};
							end
							z          = (d[7:0] == 8'h00);
							sr_d[FL_V] = 1'b0;
							sr_d[FL_N] = d[7];
							sr_d[FL_Z] = z;
							sr_d[FL_C] = ~z;
						end
						OP_PUSH: begin
							sp_d  = sp_q - WORD_STEP;
							res_d = byt ? {12'h000, d[7:0]} : d;
							wr_d  = 1'b1;
						end
						OP_CALL: begin
							sp_d  = sp_q - WORD_STEP;
							res_d = pcx;
							pc_d  = {4'h0, d[15:0]};
							wr_d  = 1'b1;
						end
						OP_IRET: begin
							sr_d  = stk0_q[15:0];
							pc_d  = stk1_q;
							sp_d  = sp_q + PAIR_STEP;
							cyc_d = CY_IRET;
						end
						default: begin
							bad_d = 1'b1;
						end
					endcase
					case (op_q[9:7])
						OP_ROTC, OP_SHRA, OP_SWAP, OP_SEXT: begin
							cyc_d = CY_ROT[{mode, 2'b00} +: 4];
						end
						OP_PUSH: begin
							cyc_d = CY_PUSH[{mode, 2'b00} +: 4];
						end
						OP_CALL: begin
							cyc_d = CY_CALL[{mode, 2'b00} +: 4];
						end
						default: begin
						end
					endcase
					// Immediate destinations make no sense for in-place operations.
					if ((mode == M_IMM) && (op_q[9:7] < OP_PUSH)) begin
						bad_d = 1'b1;
						cyc_d = 4'h1;
						res_d = d;
						sr_d  = sr_q;
					end
				end else begin
					bad_d = 1'b1;
				end
			end
		endcase
	end

	// --------------------------------------------------------------
	// Sequencing: results stay pending until the last cycle.
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= S_IDLE;
			cnt_q   <= 4'h0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (start) begin
						state_q <= S_RUN;
						cnt_q   <= cyc_d - 4'h1;
					end
				end
				S_RUN: begin
					if (cnt_q == 4'h0) begin
						state_q <= S_IDLE;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p_res_q <= 20'h00000;
			p_pc_q  <= PC_RST;
			p_sp_q  <= SP_RST;
			p_sr_q  <= SR_RST;
			info_q  <= 8'h00;
			cyc_q   <= 4'h0;
		end else if (start) begin
			p_res_q <= res_d;
			p_pc_q  <= pc_d;
			p_sp_q  <= sp_d;
			p_sr_q  <= sr_d;
			cyc_q   <= cyc_d;
			info_q  <= {(kind == K_INSTR) ? (ext ? 2'd2 : 2'd1) : 2'd0,
			            2'b00, bad_d, wr_d, ext & (kind == K_INSTR), tkn};
		end
	end

	// Done is only cleared by a new start, which cannot meet a commit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q <= 1'b0;
		end else if (commit) begin
			done_q <= 1'b1;
		end else if (start) begin
			done_q <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Architectural state; software writes are refused while busy.
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_q <= PC_RST;
		end else if (commit) begin
			pc_q <= p_pc_q;
		end else if (wr_acc && !busy && paddr == A_PC) begin
			pc_q <= pwdata[19:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_q <= SP_RST;
		end else if (commit) begin
			sp_q <= p_sp_q;
		end else if (wr_acc && !busy && paddr == A_SP) begin
			sp_q <= pwdata[19:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr_q <= SR_RST;
		end else if (commit) begin
			sr_q <= p_sr_q;
		end else if (wr_acc && !busy && paddr == A_SR) begin
			sr_q <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_q <= 20'h00000;
		end else if (commit) begin
			res_q <= p_res_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_q   <= 16'h0000;
			opnd_q <= 20'h00000;
			stk0_q <= 20'h00000;
			stk1_q <= 20'h00000;
		end else if (wr_acc && !busy) begin
			case (paddr)
				A_OPC:  op_q   <= pwdata[15:0];
				A_OPND: opnd_q <= pwdata[19:0];
				A_STK0: stk0_q <= pwdata[19:0];
				A_STK1: stk1_q <= pwdata[19:0];
				default: begin
				end
			endcase
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

endmodule // cpsx_exec

`default_nettype wire

// File: testbench/cpsx_exec_monitor.sv
// Checker for the register port of the execution unit.
// Assumes it is bound to cpsx_exec and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module cpsx_exec_monitor
	import cpsx_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	// ------------------------------------------------------------
	// Port assertions.
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire logic setup = psel && !penable;
	wire logic rd_ok = pready && !pwrite;

	ready_next_a: assert property (setup |=> pready && penable)
		else $error("no answer after setup");
	ready_once_a: assert property (pready |=> !pready)
		else $error("answer held two cycles");
	err_unmap_a: assert property (setup && paddr > 8'h27 |=> pslverr)
		else $error("unmapped access not refused");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without answer");
	ctrl_zero_a: assert property (rd_ok && paddr == A_CTRL |-> prdata == 32'h0)
		else $error("control reads nonzero");
	pc_width_a: assert property (rd_ok && paddr == A_PC |-> prdata[31:20] == 12'h0)
		else $error("counter wider than 20 bits");
	flag_width_a: assert property (rd_ok && paddr == A_SR |-> prdata[31:16] == 16'h0)
		else $error("status word too wide");
	stat_form_a: assert property (rd_ok && paddr == A_STAT |->
		prdata[31:14] == 18'h0 && prdata[11:8] <= CY_IRQ && prdata[13:12] != 2'h3)
		else $error("status fields out of range");

	cover property (setup && pwrite && paddr == A_CTRL);
	cover property (pready && pslverr);
	cover property (rd_ok && paddr == A_STAT && prdata[ST_TAKEN]);
endmodule // cpsx_exec_monitor

bind cpsx_exec cpsx_exec_monitor i_cpsx_exec_monitor (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

`default_nettype wire

// File: testbench/cpsx_apb_host.sv
// Software side of the unit: an APB master that runs one transfer per call.
// Assumes the caller starts a transfer only after reset has been released.
`timescale 1ns/1ps
`default_nettype none

module cpsx_apb_host (
	input  wire logic        pclk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [7:0]  paddr,
	output var  logic [31:0] pwdata,
	output var  logic [3:0]  pstrb
);
	// ------------------------------------------------------------
	// Transfer task.
	// ------------------------------------------------------------
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
	end

	// An idle edge precedes each setup, so no signal is driven twice in one step.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // cpsx_apb_host

`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the execution unit, driven through the APB host model.
// Assumes the unit answers each setup in the next cycle and reports busy in STATUS.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import cpsx_pkg::*;
	// ------------------------------------------------------------
	// Clock, reset, instances.
	// ------------------------------------------------------------
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q, r_res, r_sr, r_pc, r_sp, r_st;
	logic [3:0]  pstrb;
	int          fails = 0;
	int          n_checks = 0;
	int          cyc = 0;

	always #50 pclk = ~pclk;

	cpsx_exec i_cpsx_exec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	cpsx_apb_host i_cpsx_apb_host (.pclk(pclk), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb));

	// A hang in a polling loop is cut off here.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_cpsx_apb_host.xfer(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a);
		i_cpsx_apb_host.xfer(1'b0, a, 32'h0, q, e);
	endtask

	task automatic run(input logic [2:0] c, input logic [15:0] op, input logic [19:0] v,
			input logic [15:0] sr);
		wr(A_OPC, {16'h0, op});
		wr(A_OPND, {12'h0, v});
		wr(A_SR, {16'h0, sr});
		wr(A_PC, 32'h10000);
		wr(A_SP, 32'h00400);
		wr(A_CTRL, {29'h0, c});
		rd(A_STAT);
		while (q[ST_BUSY] !== 1'b0) begin
			rd(A_STAT);
		end
		r_st = q;
		rd(A_RES);
		r_res = q;
		rd(A_SR);
		r_sr = q;
		rd(A_PC);
		r_pc = q;
		rd(A_SP);
		r_sp = q;
	endtask

	// ------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------
	task automatic t_reset();
		rd(A_PC);
		chk(q, 32'h0);
		chk({31'h0, e}, 32'h0);
		rd(A_CTRL);
		chk(q, 32'h0);
		rd(8'h40);
		chk({31'h0, e}, 32'h1);
	endtask

	task automatic t_modes();
		logic [1:0]  as_m [6] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h1, 2'h1};
		logic [3:0]  rg_m [6] = '{4'h5, 4'h5, 4'h5, 4'h0, 4'h5, 4'h2};
		logic [2:0]  op_m [4] = '{OP_ROTC, OP_SWAP, OP_PUSH, OP_CALL};
		logic [23:0] cy_m [4] = '{CY_ROT, CY_ROT, CY_PUSH, CY_CALL};
		for (int k = 0; k < 4; k++) begin
			for (int m = 0; m < 6; m++) begin
				if (k > 1 || m != 3) begin
					run(3'h1, {F2_PFX, op_m[k], 1'b0, as_m[m], rg_m[m]}, 20'h00100, 16'h0);
					chk(r_st[ST_CYC +: 4], cy_m[k][4*m +: 4]);
					chk(r_st[ST_EXT], m >= 3);
					chk(r_st[ST_WORDS +: 2], (m >= 3) ? 2 : 1);
				end
			end
		end
	endtask

	task automatic t_shifts();
		run(3'h1, {F2_PFX, OP_ROTC, 7'h05}, 20'h00001, 16'h0101);
		chk(r_res, 32'h08000);
		chk(r_sr, 32'h0005);
		run(3'h1, {F2_PFX, OP_SHRA, 7'h64}, 20'h00081, 16'h0100);
		chk(r_res, 32'h000c0);
		chk(r_sr, 32'h0005);
		run(3'h1, {F2_PFX, OP_SWAP, 7'h15}, 20'h01234, 16'h0107);
		chk(r_res, 32'h03412);
		chk(r_sr, 32'h0107);
		chk(r_pc, 32'h10002);
		run(3'h1, {F2_PFX, OP_SEXT, 7'h06}, 20'h00080, 16'h0100);
		chk(r_res, 32'hfff80);
		chk(r_sr, 32'h0005);
		run(3'h1, {F2_PFX, OP_SEXT, 7'h12}, 20'h0ff00, 16'h0005);
		chk(r_res, 32'h00000);
		chk(r_sr, 32'h0002);
		run(3'h1, {F2_PFX, OP_ROTC, 7'h30}, 20'h00003, 16'h0100);
		chk(r_sr, 32'h0100);
		chk(r_pc, 32'h10002);
		chk(r_st[ST_BAD], 1'b1);
		chk(r_st[ST_CYC +: 4], 4'h1);
		run(3'h1, {F2_PFX, 3'h7, 7'h05}, 20'h00003, 16'h0100);
		chk(r_st[ST_BAD], 1'b1);
		chk(r_pc, 32'h10000);
	endtask

	task automatic t_stack();
		run(3'h1, {F2_PFX, OP_PUSH, 7'h30}, 20'h0abcd, 16'h0107);
		chk(r_sp, 32'h003fe);
		chk(r_res, 32'h0abcd);
		chk(r_sr, 32'h0107);
		chk(r_st[ST_WR], 1'b1);
		run(3'h1, {F2_PFX, OP_PUSH, 7'h45}, 20'h0abcd, 16'h0);
		chk(r_res, 32'h000cd);
		run(3'h1, {F2_PFX, OP_CALL, 7'h12}, 20'h1abcd, 16'h0107);
		chk(r_pc, 32'h0abcd);
		chk(r_res, 32'h10002);
		chk(r_sr, 32'h0107);
		wr(A_STK0, 32'h0105);
		wr(A_STK1, 32'h02346);
		run(3'h1, {F2_PFX, OP_IRET, 7'h00}, 20'h0, 16'h0);
		chk({r_sr[15:0], r_pc[15:0]}, 32'h01052346);
		chk(r_sp, 32'h00404);
		chk(r_st[ST_CYC +: 4], CY_IRET);
		wr(A_STK0, 32'h0abce);
		run(3'h4, 16'h0, 20'h0, 16'h0107);
		chk(r_pc, 32'h0abce);
		chk(r_sp, 32'h00402);
		chk(r_st[ST_CYC +: 4], CY_EXIT);
		run(3'h2, 16'h0, 20'h0f000, 16'h0107);
		chk(r_pc, 32'h0f000);
		chk(r_res, 32'h10000);
		chk(r_st[ST_CYC +: 4], CY_IRQ);
		chk(r_sp, 32'h003fc);
		chk(r_st[ST_WORDS +: 2], 2'h0);
		// A counter write that lands while busy must be ignored.
		wr(A_CTRL, 32'h2);
		wr(A_PC, 32'h00123);
		rd(A_STAT);
		while (q[ST_BUSY] !== 1'b0) begin
			rd(A_STAT);
		end
		rd(A_PC);
		chk(q, 32'h0f000);
		rd(A_SP);
		chk(q, 32'h003f8);
	endtask

	task automatic t_jumps();
		logic [15:0] srs [3] = '{16'h0000, 16'h0107, 16'h0004};
		logic [9:0]  off;
		logic [7:0]  cv;
		for (int s = 0; s < 3; s++) begin
			for (int k = 0; k < 8; k++) begin
				off = k[0] ? 10'h1ff : 10'h200;
				cv = {1'b1, srs[s][2] ^ srs[s][8], !(srs[s][2] ^ srs[s][8]), srs[s][2],
					srs[s][0], !srs[s][0], srs[s][1], !srs[s][1]};
				run(3'h1, {J_PFX, k[2:0], off}, 20'h0, srs[s]);
				chk(r_st[ST_TAKEN], cv[k]);
				chk(r_pc, cv[k] ? 32'h10000 + {{21{off[9]}}, off, 1'b0} : 32'h10000);
				chk(r_sr, srs[s]);
				chk(r_st[ST_CYC +: 4], CY_JUMP);
			end
		end
	endtask

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_modes();
		t_shifts();
		t_stack();
		t_jumps();
		test_done();
	end
endmodule // tb_top

`default_nettype wire
